// *** rtl/sai_pkg.sv ***
// Purpose: shared types and constants for the serial audio input receiver
// Assumes: 125 MHz system clock; bit clock, frame select and data come from the source
// Notes: register map, control layout, timing constants and detection windows
package sai_pkg;

    // register offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] SAI_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SAI_ADDR_STATUS = 8'h04;
    localparam logic [7:0] SAI_ADDR_L0 = 8'h08;
    localparam logic [7:0] SAI_ADDR_R0 = 8'h0C;
    localparam logic [7:0] SAI_ADDR_L1 = 8'h10;
    localparam logic [7:0] SAI_ADDR_R1 = 8'h14;

    localparam int SAI_CTRL_W = 12;
    // I2S, 24-bit words, autodetection on
    localparam logic [11:0] SAI_CTRL_RST = 12'h01C;

    // clock period and timing
    localparam int SAI_CLK_NS = 8;
    localparam int SAI_MCLK_TIMEOUT_NS = 200;
    localparam int SAI_MCLK_TIMEOUT_CYC = SAI_MCLK_TIMEOUT_NS / SAI_CLK_NS;
    localparam logic [4:0] SAI_MCLK_STABLE_EDGES = 5'h10;

    // frame period windows for rate classes (longest frame first)
    localparam int SAI_TMAX_NS = 32000;
    localparam int SAI_T32K_MIN_NS = 26400;
    localparam int SAI_TNORM_MIN_NS = 15000;
    localparam int SAI_TDBL_MIN_NS = 7800;
    localparam int SAI_TQUAD_MIN_NS = 4000;
    localparam int SAI_TMAX_CYC = SAI_TMAX_NS / SAI_CLK_NS;
    localparam int SAI_T32K_MIN_CYC = (SAI_T32K_MIN_NS + SAI_CLK_NS - 1) / SAI_CLK_NS;
    localparam int SAI_TNORM_MIN_CYC = (SAI_TNORM_MIN_NS + SAI_CLK_NS - 1) / SAI_CLK_NS;
    localparam int SAI_TDBL_MIN_CYC = (SAI_TDBL_MIN_NS + SAI_CLK_NS - 1) / SAI_CLK_NS;
    localparam int SAI_TQUAD_MIN_CYC = (SAI_TQUAD_MIN_NS + SAI_CLK_NS - 1) / SAI_CLK_NS;
    localparam logic [11:0] SAI_PER_MAX = 12'hFFF;

    // accepted bit clocks per frame
    localparam logic [6:0] SAI_FRAME_32 = 7'h20;
    localparam logic [6:0] SAI_FRAME_48 = 7'h30;
    localparam logic [6:0] SAI_FRAME_64 = 7'h40;
    localparam logic [5:0] SAI_CNT_MAX = 6'h3F;

    // pwm output rate multiples
    localparam logic [3:0] SAI_PWM_MULT_6 = 4'h6;
    localparam logic [3:0] SAI_PWM_MULT_7 = 4'h7;
    localparam logic [3:0] SAI_PWM_MULT_8 = 4'h8;

    typedef enum logic [1:0] {
        SAI_FMT_I2S = 2'h0,
        SAI_FMT_LJ = 2'h1,
        SAI_FMT_RJ = 2'h2,
        SAI_FMT_RSV = 2'h3
    } sai_fmt_t;

    typedef enum logic [1:0] {
        SAI_WL_16 = 2'h0,
        SAI_WL_18 = 2'h1,
        SAI_WL_20 = 2'h2,
        SAI_WL_24 = 2'h3
    } sai_wlen_t;

    typedef enum logic [2:0] {
        SAI_RATE_32K = 3'h0,
        SAI_RATE_NORMAL = 3'h1,
        SAI_RATE_DOUBLE = 3'h2,
        SAI_RATE_QUAD = 3'h3,
        SAI_RATE_NONE = 3'h4
    } sai_rate_t;

    typedef enum logic [1:0] {
        SAI_AM_7X = 2'h0,
        SAI_AM_8X = 2'h1,
        SAI_AM_6X = 2'h2,
        SAI_AM_RSV = 2'h3
    } sai_am_t;

    typedef enum logic [0:0] {
        SAI_LNK_HUNT = 1'h0,
        SAI_LNK_RUN = 1'h1
    } sai_lnk_st_t;

    // control register layout, bit 11 down to bit 0
    typedef struct packed {
        sai_rate_t man_rate;
        logic deemph;
        sai_am_t am_sel;
        logic am_en;
        logic auto_en;
        sai_wlen_t wlen;
        sai_fmt_t fmt;
    } sai_ctrl_t;

    typedef struct packed {
        sai_fmt_t fmt;
        sai_wlen_t wlen;
    } sai_lcfg_t;

    typedef struct packed {
        logic [23:0] l0;
        logic [23:0] r0;
        logic [23:0] l1;
        logic [23:0] r1;
        logic ratio_ok;
    } sai_frame_t;

    typedef struct packed {
        sai_rate_t rate;
        logic src_mclk;
        logic [3:0] pwm_mult;
    } sai_clkctl_t;

endpackage : sai_pkg

// *** rtl/sai_rx.sv ***
// Purpose: serial audio input receiver with clock check and rate detection
// Assumes: bit clock is the link clock; frame select and data change on its falling edge
// Notes: frames cross to the system clock by toggle; config crosses as quasi-static levels
// Behaviour
// - I2S frame select low carries left, high carries right.
// - I2S word MSB sits one bit clock after the frame-select edge.
// - data MSB first, captured on rising bit clock edge.
// - I2S and left-justified ignore bits after the word length.
// - left-justified frame select high carries left, low carries right.
// - left-justified MSB sits in the bit of the frame-select edge.
// - frames of other than 32, 48 or 64 bits are rejected.
// - use master clock when stable, else internal oscillator.
// - autodetect classifies 32k, normal, double or quad speed.
// - autodetect can be disabled; then manual rate from register.
// - AM avoidance sets PWM rate to 7, 8 or 6 times fs.
// - accept 32 to 192 kHz and 16, 18, 20, 24-bit words.
// - samples are two's complement and handled as signed.
// - right-justified LSB ends each slot, leading bits ignored.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module sai_rx
    import sai_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire logic SCLK_I,
    input wire logic LRCLK_I,
    input wire logic [1:0] SERIAL_AUDIO_INPUTS_I,
    input wire logic MCLK_I,
    output sai_pkg::sai_frame_t SAMPLE_O,
    output logic SAMPLE_VALID_O,
    output sai_pkg::sai_clkctl_t CLK_CTRL_O
);
    import sai_pkg::*;

    typedef struct packed {
        sai_lnk_st_t st;
        logic lr1;
        logic lr2;
        logic [5:0] cnt;
        logic [31:0] sh0;
        logic [31:0] sh1;
        logic [5:0] len_l;
        logic have_left;
        logic [23:0] hl0;
        logic [23:0] hl1;
        sai_frame_t frm;
        logic tgl;
    } sai_lnk_t;

    typedef struct packed {
        sai_ctrl_t ctrl;
        logic [31:0] rdata;
        logic mclk_prev;
        logic [4:0] mclk_cnt;
        logic [4:0] mclk_good;
        logic mclk_ok;
        logic tgl_prev;
        logic [11:0] per;
        sai_rate_t det;
        sai_frame_t smp;
        logic valid;
        logic ratio_ok;
        sai_clkctl_t cc;
    } sai_sys_t;

    sai_lnk_t l_q;
    sai_lnk_t l_d;
    sai_sys_t s_q;
    sai_sys_t s_d;
    logic lrst;
    sai_lcfg_t lcfg;
    logic tgl_s;
    logic mclk_s;

    // link-side helpers
    logic cur_lr;
    logic prev_lr;
    logic bnd;
    logic is_left;
    logic [5:0] wl;
    logic [5:0] sh_amt;
    logic [4:0] pad;
    logic [31:0] sel0;
    logic [31:0] sel1;
    logic [23:0] w0;
    logic [23:0] w1;
    logic [6:0] fbits;
    // system-side helpers
    logic evt;
    logic mclk_edge;
    logic auto_eff;
    sai_rate_t cls;
    logic [31:0] rmux;

    // reset and config enter the link domain; config is static while frames run
    sai_sync #(.W(1)) u_lrst (
        .clk_i(SCLK_I),
        .rst_i(1'b0),
        .d_i(SYS_RST_I),
        .q_o(lrst)
    );
    sai_sync #(.W(4)) u_cfg (
        .clk_i(SCLK_I),
        .rst_i(lrst),
        .d_i({s_q.ctrl.fmt, s_q.ctrl.wlen}),
        .q_o(lcfg)
    );
    sai_sync #(.W(1)) u_tgl (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .d_i(l_q.tgl),
        .q_o(tgl_s)
    );
    sai_sync #(.W(1)) u_mclk (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .d_i(MCLK_I),
        .q_o(mclk_s)
    );

    // ---------------- link domain ----------------
    always_comb begin
        l_d = l_q;
        // I2S boundaries are seen one bit late so every slot starts at its MSB
        cur_lr = (lcfg.fmt == SAI_FMT_I2S) ? l_q.lr1 : LRCLK_I;
        prev_lr = (lcfg.fmt == SAI_FMT_I2S) ? l_q.lr2 : l_q.lr1;
        bnd = (cur_lr != prev_lr);
        is_left = (lcfg.fmt == SAI_FMT_I2S) ? ~prev_lr : prev_lr;
        case (lcfg.wlen)
            SAI_WL_16: wl = 6'h10;
            SAI_WL_18: wl = 6'h12;
            SAI_WL_20: wl = 6'h14;
            default: wl = 6'h18;
        endcase
        // trailing bits of the slot are dropped by shifting them out
        sh_amt = (lcfg.fmt == SAI_FMT_RJ) ? 6'h00 : l_q.cnt - wl;
        pad = 5'h18 - wl[4:0];
        sel0 = l_q.sh0 >> sh_amt;
        sel1 = l_q.sh1 >> sh_amt;
        // left-aligned: word MSB lands on bit 23, so the sign is kept
        w0 = sel0[23:0] << pad;
        w1 = sel1[23:0] << pad;
        fbits = {1'b0, l_q.len_l} + {1'b0, l_q.cnt};
        l_d.lr1 = LRCLK_I;
        l_d.lr2 = l_q.lr1;
        l_d.sh0 = {l_q.sh0[30:0], SERIAL_AUDIO_INPUTS_I[0]};
        l_d.sh1 = {l_q.sh1[30:0], SERIAL_AUDIO_INPUTS_I[1]};
        if (bnd) begin
            l_d.cnt = 6'h01;
        end else if (l_q.cnt != SAI_CNT_MAX) begin
            l_d.cnt = l_q.cnt + 6'h01;
        end
        case (l_q.st)
            SAI_LNK_HUNT: begin
                if (bnd) begin
                    l_d.st = SAI_LNK_RUN;
                end
            end
            SAI_LNK_RUN: begin
                if (bnd && is_left) begin
                    l_d.hl0 = w0;
                    l_d.hl1 = w1;
                    l_d.len_l = l_q.cnt;
                    l_d.have_left = 1'b1;
                end else if (bnd && l_q.have_left) begin
                    l_d.frm.l0 = l_q.hl0;
                    l_d.frm.l1 = l_q.hl1;
                    l_d.frm.r0 = w0;
                    l_d.frm.r1 = w1;
                    l_d.frm.ratio_ok = (fbits == SAI_FRAME_32) || (fbits == SAI_FRAME_48)
                        || (fbits == SAI_FRAME_64);
                    l_d.tgl = ~l_q.tgl;
                    l_d.have_left = 1'b0;
                end
            end
            default: l_d.st = SAI_LNK_HUNT;
        endcase
    end

    always_ff @(posedge SCLK_I) begin
        if (lrst) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // ---------------- system domain ----------------
    always_comb begin
        s_d = s_q;
        s_d.rdata = 32'h0000_0000;
        s_d.valid = 1'b0;
        s_d.mclk_prev = mclk_s;
        s_d.tgl_prev = tgl_s;
        evt = (tgl_s != s_q.tgl_prev);
        mclk_edge = mclk_s & ~s_q.mclk_prev;
        // manual rate forced while AM avoidance or de-emphasis is on
        auto_eff = s_q.ctrl.auto_en & ~s_q.ctrl.am_en & ~s_q.ctrl.deemph;
        if (s_q.per > 12'(SAI_TMAX_CYC)) begin
            cls = SAI_RATE_NONE;
        end else if (s_q.per >= 12'(SAI_T32K_MIN_CYC)) begin
            cls = SAI_RATE_32K;
        end else if (s_q.per >= 12'(SAI_TNORM_MIN_CYC)) begin
            cls = SAI_RATE_NORMAL;
        end else if (s_q.per >= 12'(SAI_TDBL_MIN_CYC)) begin
            cls = SAI_RATE_DOUBLE;
        end else if (s_q.per >= 12'(SAI_TQUAD_MIN_CYC)) begin
            cls = SAI_RATE_QUAD;
        end else begin
            cls = SAI_RATE_NONE;
        end
        case (ADDR_I)
            SAI_ADDR_CTRL: rmux = {20'h00000, s_q.ctrl};
            SAI_ADDR_STATUS: rmux = {22'h000000, s_q.ratio_ok, s_q.mclk_ok, s_q.det,
                s_q.cc.rate, s_q.cc.src_mclk, 1'b0};
            SAI_ADDR_L0: rmux = {{8{s_q.smp.l0[23]}}, s_q.smp.l0};
            SAI_ADDR_R0: rmux = {{8{s_q.smp.r0[23]}}, s_q.smp.r0};
            SAI_ADDR_L1: rmux = {{8{s_q.smp.l1[23]}}, s_q.smp.l1};
            SAI_ADDR_R1: rmux = {{8{s_q.smp.r1[23]}}, s_q.smp.r1};
            default: rmux = 32'h0000_0000;
        endcase
        if (RD_I) begin
            s_d.rdata = rmux;
        end
        if (WR_I && ADDR_I == SAI_ADDR_CTRL) begin
            s_d.ctrl = WDATA_I[SAI_CTRL_W-1:0];
        end
        // master clock watchdog: any gap longer than the timeout restarts qualification
        if (mclk_edge) begin
            s_d.mclk_cnt = 5'h00;
            if (s_q.mclk_good != SAI_MCLK_STABLE_EDGES) begin
                s_d.mclk_good = s_q.mclk_good + 5'h01;
            end
        end else if (s_q.mclk_cnt == 5'(SAI_MCLK_TIMEOUT_CYC)) begin
            s_d.mclk_good = 5'h00;
        end else begin
            s_d.mclk_cnt = s_q.mclk_cnt + 5'h01;
        end
        s_d.mclk_ok = (s_q.mclk_good == SAI_MCLK_STABLE_EDGES);
        // frame period counts system cycles between frames, one frame per fs
        if (evt) begin
            s_d.per = 12'h001;
            s_d.det = cls;
            s_d.ratio_ok = l_q.frm.ratio_ok;
            if (l_q.frm.ratio_ok) begin
                // holder in the link domain is stable for a whole frame after the toggle
                s_d.smp = l_q.frm;
                s_d.valid = 1'b1;
            end
        end else if (s_q.per != SAI_PER_MAX) begin
            s_d.per = s_q.per + 12'h001;
        end else begin
            s_d.det = SAI_RATE_NONE;
        end
        s_d.cc.rate = auto_eff ? s_q.det : s_q.ctrl.man_rate;
        s_d.cc.src_mclk = s_q.mclk_ok;
        if (!s_q.ctrl.am_en) begin
            s_d.cc.pwm_mult = SAI_PWM_MULT_8;
        end else begin
            case (s_q.ctrl.am_sel)
                SAI_AM_7X: s_d.cc.pwm_mult = SAI_PWM_MULT_7;
                SAI_AM_6X: s_d.cc.pwm_mult = SAI_PWM_MULT_6;
                default: s_d.cc.pwm_mult = SAI_PWM_MULT_8;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            s_q <= '0;
            s_q.ctrl <= SAI_CTRL_RST;
            s_q.det <= SAI_RATE_NONE;
            s_q.cc.rate <= SAI_RATE_NONE;
            s_q.cc.pwm_mult <= SAI_PWM_MULT_8;
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA_O = s_q.rdata;
    assign SAMPLE_O = s_q.smp;
    assign SAMPLE_VALID_O = s_q.valid;
    assign CLK_CTRL_O = s_q.cc;

    // ---------------- checks ----------------
    property p_lnk_msb_start;
        @(posedge SCLK_I) disable iff (lrst) (!lrst && bnd) |=> (l_q.cnt == 6'h01);
    endproperty
    a_lnk_msb_start: assert property (p_lnk_msb_start) else $error("slot count not restarted");

    property p_lnk_shift;
        @(posedge SCLK_I) disable iff (lrst)
            !lrst |=> (l_q.sh0[0] == $past(SERIAL_AUDIO_INPUTS_I[0]))
            && (l_q.sh0[31:1] == $past(l_q.sh0[30:0]));
    endproperty
    a_lnk_shift: assert property (p_lnk_shift) else $error("data not shifted msb first");

    property p_lnk_i2s_left;
        @(posedge SCLK_I) disable iff (lrst)
            (l_q.st == SAI_LNK_RUN && lcfg.fmt == SAI_FMT_I2S && bnd && !l_q.lr2)
            |=> l_q.have_left;
    endproperty
    a_lnk_i2s_left: assert property (p_lnk_i2s_left) else $error("i2s low slot not left");

    property p_lnk_lj_left;
        @(posedge SCLK_I) disable iff (lrst)
            (l_q.st == SAI_LNK_RUN && lcfg.fmt == SAI_FMT_LJ && bnd && l_q.lr1)
            |=> (l_q.have_left && l_q.hl0 == $past(w0));
    endproperty
    a_lnk_lj_left: assert property (p_lnk_lj_left) else $error("lj high slot not left");

    property p_lnk_trail;
        @(posedge SCLK_I) disable iff (lrst)
            (l_q.st == SAI_LNK_RUN && lcfg.wlen == SAI_WL_16 && bnd && is_left)
            |=> (l_q.hl0[7:0] == 8'h00) && (l_q.hl1[7:0] == 8'h00);
    endproperty
    a_lnk_trail: assert property (p_lnk_trail) else $error("bits past word length kept");

    property p_lnk_sign;
        @(posedge SCLK_I) disable iff (lrst)
            (l_q.st == SAI_LNK_RUN && lcfg.fmt == SAI_FMT_RJ && lcfg.wlen == SAI_WL_24
            && bnd && is_left) |=> (l_q.hl0 == $past(l_q.sh0[23:0]));
    endproperty
    a_lnk_sign: assert property (p_lnk_sign) else $error("rj word misplaced");

    property p_sys_ratio;
        @(posedge CLK_I) disable iff (SYS_RST_I)
            (evt && !l_q.frm.ratio_ok) |=> !SAMPLE_VALID_O && !s_q.ratio_ok;
    endproperty
    a_sys_ratio: assert property (p_sys_ratio) else $error("bad ratio frame passed");

    property p_sys_src;
        @(posedge CLK_I) disable iff (SYS_RST_I)
            (!mclk_edge && s_q.mclk_cnt == 5'(SAI_MCLK_TIMEOUT_CYC)) |-> ##3 !CLK_CTRL_O.src_mclk;
    endproperty
    a_sys_src: assert property (p_sys_src) else $error("lost master clock still used");

    property p_sys_manual;
        @(posedge CLK_I) disable iff (SYS_RST_I)
            !auto_eff |=> (CLK_CTRL_O.rate == $past(s_q.ctrl.man_rate));
    endproperty
    a_sys_manual: assert property (p_sys_manual) else $error("manual rate not applied");

    property p_sys_am;
        @(posedge CLK_I) disable iff (SYS_RST_I)
            (s_q.ctrl.am_en && s_q.ctrl.am_sel == SAI_AM_6X) |=> (CLK_CTRL_O.pwm_mult == 4'h6);
    endproperty
    a_sys_am: assert property (p_sys_am) else $error("am 6x multiple wrong");

    property p_sys_quad;
        @(posedge CLK_I) disable iff (SYS_RST_I)
            (evt && s_q.per >= 12'(SAI_TQUAD_MIN_CYC) && s_q.per < 12'(SAI_TDBL_MIN_CYC))
            |=> (s_q.det == SAI_RATE_QUAD);
    endproperty
    a_sys_quad: assert property (p_sys_quad) else $error("quad speed not detected");

    c_i2s_frame: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
        SAMPLE_VALID_O && s_q.ctrl.fmt == SAI_FMT_I2S);
    c_rj_frame: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
        SAMPLE_VALID_O && s_q.ctrl.fmt == SAI_FMT_RJ);
    c_mclk_lost: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
        $fell(CLK_CTRL_O.src_mclk));
    c_normal: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
        CLK_CTRL_O.rate == SAI_RATE_NORMAL);

endmodule : sai_rx
`default_nettype wire

// *** rtl/sai_sync.sv ***
// Purpose: two-stage synchroniser for levels entering a clock domain
// Assumes: multi-bit use only for quasi-static values
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module sai_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : sai_sync
`default_nettype wire

// *** verif/sai_rx_test.sv ***
// Purpose: self-checking bench for the serial audio receiver
// Assumes: bit clock from the source model, 64 ns unless a rate test stretches it
// Notes: reset spans several bit clocks since the link reset is synchronised
`timescale 1ns/1ns
`default_nettype none
module sai_rx_test;
    import sai_pkg::*;
    typedef struct packed {
        sai_fmt_t f;
        logic [6:0] slot;
        logic [4:0] wl;
    } sai_row_t;
    logic CLK_I = 1'b0;
    logic SYS_RST_I = 1'b1;
    logic [7:0] ADDR_I = 8'h00;
    logic [31:0] WDATA_I = 32'h0;
    logic WR_I = 1'b0;
    logic RD_I = 1'b0;
    logic MCLK_I = 1'b0;
    logic [31:0] RDATA_O;
    wire logic sclk, lrclk;
    wire logic [1:0] sd;
    sai_frame_t SAMPLE_O;
    logic SAMPLE_VALID_O;
    sai_clkctl_t CLK_CTRL_O;
    int fails = 0, cmp_count = 0, n_valid = 0, cyc = 0, t, v;
    logic mclk_on = 1'b0;
    logic [1:0] mdiv = 2'h0;
    logic [31:0] rv;
    logic [95:0] w = 96'h9E3779B97F4A7C15F39CC060;
    logic [23:0] m;
    int hp [4] = '{32, 64, 128, 220};
    sai_rate_t re [4] = '{SAI_RATE_QUAD, SAI_RATE_DOUBLE, SAI_RATE_NORMAL, SAI_RATE_32K};
    logic [11:0] mc [5] = '{12'h400, 12'h310, 12'h030, 12'h670, 12'h2B0};
    sai_rate_t mr [5] = '{SAI_RATE_DOUBLE, SAI_RATE_NORMAL, SAI_RATE_32K, SAI_RATE_QUAD,
        SAI_RATE_NORMAL};
    logic [3:0] mp [5] = '{4'h8, 4'h8, 4'h7, 4'h8, 4'h6};
    sai_row_t rows [10] = '{'{SAI_FMT_I2S, 7'h20, 5'h18}, '{SAI_FMT_LJ, 7'h20, 5'h18},
        '{SAI_FMT_RJ, 7'h20, 5'h18}, '{SAI_FMT_I2S, 7'h10, 5'h10}, '{SAI_FMT_LJ, 7'h18, 5'h12},
        '{SAI_FMT_RJ, 7'h18, 5'h14}, '{SAI_FMT_I2S, 7'h20, 5'h14}, '{SAI_FMT_LJ, 7'h10, 5'h10},
        '{SAI_FMT_RJ, 7'h10, 5'h10}, '{SAI_FMT_I2S, 7'h18, 5'h12}};
    sai_rx DUT (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
        .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SCLK_I(sclk), .LRCLK_I(lrclk),
        .SERIAL_AUDIO_INPUTS_I(sd), .MCLK_I(MCLK_I), .SAMPLE_O(SAMPLE_O),
        .SAMPLE_VALID_O(SAMPLE_VALID_O), .CLK_CTRL_O(CLK_CTRL_O));
    sai_src SRC (.sclk_o(sclk), .lrclk_o(lrclk), .sd_o(sd));
    always #4 CLK_I = ~CLK_I;
    // master clock at 48 ns, slow enough for the two-flop sampler
    always @(posedge CLK_I) begin
        cyc <= cyc + 1;
        if (SAMPLE_VALID_O === 1'b1) n_valid <= n_valid + 1;
        if (mclk_on) mdiv <= (mdiv == 2'h2) ? 2'h0 : mdiv + 2'h1;
        if (mclk_on && mdiv == 2'h2) MCLK_I <= ~MCLK_I;
        if (cyc == 90000) begin
            fails = fails + 1;
            summarize();
        end
    end
    task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge CLK_I);
        WR_I <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge CLK_I);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        #1 rv = RDATA_O;
    endtask : rd
    task automatic wait_valid(input int target);
        t = 0;
        while (n_valid < target && t < 6000) begin
            @(posedge CLK_I);
            t++;
        end
        #1 chk(n_valid, target, "frame count");
    endtask : wait_valid
    // lead-in ends low so the first left slot opens on an edge
    task automatic send(input sai_fmt_t f, input int slot, input int wl, input int n);
        #3 SRC.idle(4, f == SAI_FMT_I2S);
        SRC.idle(1, 1'b0);
        repeat (n) SRC.frame(f, slot, wl, w);
        SRC.idle(4, f != SAI_FMT_I2S);
    endtask : send
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    initial begin
        SRC.idle(6, 1'b1);
        @(posedge CLK_I);
        SYS_RST_I <= 1'b0;
        #1 chk(CLK_CTRL_O, {SAI_RATE_NONE, 1'b0, SAI_PWM_MULT_8}, "reset clkctl");
        chk({SAMPLE_O, SAMPLE_VALID_O}, '0, "reset sample");
        wr(SAI_ADDR_STATUS, 32'hFFF);
        rd(8'h20);
        chk(rv, 32'h0, "unmapped read");
        rd(SAI_ADDR_CTRL);
        chk(rv, SAI_CTRL_RST, "ctrl reset");
        $display("test reset done");
        mclk_on <= 1'b1;
        t = 0;
        while (CLK_CTRL_O.src_mclk !== 1'b1 && t < 300) begin
            @(posedge CLK_I);
            t++;
        end
        rd(SAI_ADDR_STATUS);
        chk({rv[8], rv[1], CLK_CTRL_O.src_mclk}, 3'h7, "mclk source");
        mclk_on <= 1'b0;
        t = 0;
        while (CLK_CTRL_O.src_mclk === 1'b1 && t < 60) begin
            @(posedge CLK_I);
            t++;
        end
        chk(t >= 16 && t <= 36, 1'b1, "oscillator fallback");
        $display("test clock source done");
        for (int r = 0; r < 5; r++) begin
            wr(SAI_ADDR_CTRL, {20'h0, mc[r]});
            repeat (3) @(posedge CLK_I);
            chk({CLK_CTRL_O.rate, CLK_CTRL_O.pwm_mult}, {mr[r], mp[r]}, "manual");
        end
        $display("test manual rate done");
        foreach (rows[i]) begin
            w = {w[84:0], w[95:85]};
            m = 24'hFFFFFF << (24 - rows[i].wl);
            wr(SAI_ADDR_CTRL, {27'h0, 1'b1, (rows[i].wl == 5'h18) ? 2'h3
                : 2'((rows[i].wl - 5'h10) >> 1), rows[i].f});
            v = n_valid;
            send(rows[i].f, rows[i].slot, rows[i].wl, 1);
            wait_valid(v + 1);
            chk(SAMPLE_O, {w[95:72] & m, w[71:48] & m, w[47:24] & m, w[23:0] & m, 1'b1},
                "frame");
            rd(SAI_ADDR_R1);
            chk(rv, {{8{w[23]}}, w[23:0] & m}, "signed word");
            $display("test row %0d done", i);
        end
        wr(SAI_ADDR_CTRL, 32'h11);
        v = n_valid;
        send(SAI_FMT_LJ, 20, 16, 1);
        repeat (100) @(posedge CLK_I);
        rd(SAI_ADDR_STATUS);
        chk({n_valid, rv[9]}, {v, 1'b0}, "odd ratio");
        $display("test odd ratio done");
        wr(SAI_ADDR_CTRL, 32'h1D);
        for (int r = 0; r < 4; r++) begin
            SRC.half = hp[r];
            v = n_valid;
            send(SAI_FMT_LJ, 32, 24, 3);
            wait_valid(v + 3);
            rd(SAI_ADDR_STATUS);
            chk({CLK_CTRL_O.rate, rv[7:5]}, {re[r], re[r]}, "auto rate");
        end
        $display("test autodetect done");
        summarize();
    end
endmodule : sai_rx_test
`default_nettype wire

// *** verif/sai_src.sv ***
// Purpose: serial audio source acting as clock master for the receiver
// Assumes: bit clock stands still between calls
// Notes: idle data toggles every bit so a stale level never reads as data
`timescale 1ns/1ns
`default_nettype none
module sai_src
    import sai_pkg::*;
(
    output logic sclk_o,
    output logic lrclk_o,
    output logic [1:0] sd_o
);
    int half = 32;
    initial begin
        sclk_o = 1'b0;
        lrclk_o = 1'b1;
        sd_o = 2'h0;
    end
    // levels move at the falling edge so the rising edge sees them settled
    task automatic bit_out(input logic lr, input logic [1:0] d);
        lrclk_o = lr;
        sd_o = d;
        #half sclk_o = 1'b1;
        #half sclk_o = 1'b0;
    endtask : bit_out
    task automatic idle(input int n, input logic lr);
        repeat (n) bit_out(lr, ~sd_o);
    endtask : idle
    // w is l0, r0, l1, r1 from the top; one frame-select period per call
    task automatic frame(input sai_fmt_t f, input int slot, input int wl, input logic [95:0] w);
        int p;
        logic [1:0] d;
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < slot; k++) begin
                p = (f == SAI_FMT_RJ) ? k - slot + wl : k;
                for (int j = 0; j < 2; j++) begin
                    d[j] = (p >= 0 && p < wl) ? w[95 - 24 * (2 * j + s) - p] : k[0];
                end
                // i2s moves its edge one bit ahead of the msb
                bit_out((f == SAI_FMT_I2S) ? s[0] ^ (k == slot - 1) : !s[0], d);
            end
        end
    endtask : frame
endmodule : sai_src
`default_nettype wire
